// [verilog/irq_ctrl.sv]
// prioritised interrupt controller with vector supply to the core
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/10ps
// How it works
// - each request flag set by its source event, cleared by software write
// - flags set regardless of the matching enable bit
// - per-source enable gates a flagged request into arbitration
// - three-bit priority per source, 7 highest, 1 lowest
// - priority zero means the source is never taken
// - priority in low three bits of each nibble, top bit reads zero
// - cpu level is four bits: top in core control, low in status
// - nesting disable blocks any new source interrupt while one is serviced; traps are still taken
// - cpu level bits ignore writes while nesting disable is one
// - timed disable blocks levels 6 and below; status bit reads set meanwhile
// - program counter loaded over 24 bits with the fetched vector word
// - 126 vector words between 0x000004 and 0x0000fe
// - normal fetch from vector range raises an address error trap
// - equal priority ties go to the lowest source number
// - rank equals source number; vector number is source plus eight
// - small variant source map; unlisted sources reserved
// - large variant adds sources 17 to 22 and 41
// - interrupt sources and four traps share one priority scheme
// - first global register holds trap control, second external and table select
// - edge or level options live in the peripherals, not here
// - flags sampled at each instruction start, winner evaluated in that cycle
// - a request interrupts only above the current cpu level
// - taking an interrupt loads its level into the cpu level bits
// - traps use levels 11 to 14, top level bit set only for traps
module irq_ctrl #(
	parameter bit large_variant = 1'b1,
	parameter int stack_depth = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata_q,
	// peripheral request events, one pulse each
	input wire logic [47:0] source_event,
	input wire logic [3:0] trap_event,
	// core side
	input wire logic instr_start,
	input wire logic vector_ack,
	input wire logic [23:0] vector_word,
	input wire logic irq_return,
	input wire logic fetch_valid,
	input wire logic fetch_is_vector,
	input wire logic [23:0] fetch_addr,
	output logic irq_request_q,
	output logic [5:0] irq_vector_q,
	output logic [3:0] irq_level_q,
	output logic [23:0] vector_location_q,
	output logic pc_load_q,
	output logic [23:0] pc_value_q,
	output logic address_error_q,
	output logic [3:0] cpu_priority_level_q
);
	// nesting depth counter is four bits wide
	if (stack_depth < 1 || stack_depth > 15) begin : g_bad_depth
		$error("stack_depth must lie between 1 and 15");
	end

	localparam logic [47:0] impl_mask = large_variant ? irq_ctrl_pkg::large_sources
		: irq_ctrl_pkg::small_sources;

	typedef struct packed {
		irq_ctrl_pkg::state_type state;
		logic [47:0] flags;
		logic [47:0] enables;
		logic [47:0][2:0] prio;
		logic [14:0] ctrl1_low;
		logic nesting_disable;
		logic alt_table;
		logic [13:0] ctrl2_low;
		logic [3:0] cpu_priority_level;
		logic [irq_ctrl_pkg::timed_count_width-1:0] timed_count;
		logic [3:0] depth;
		logic [stack_depth-1:0][3:0] stack;
		logic [3:0] trap_pend;
		logic [5:0] vec;
		logic [3:0] lvl;
		logic [3:0] trap_taking;
		logic [5:0] src;
		logic [23:0] loc;
		logic req;
		logic pc_load;
		logic [23:0] pc_val;
		logic addr_err;
		logic [15:0] rdata;
	} state_reg_type;

	state_reg_type s_q;
	state_reg_type s_d;

	// best eligible source: highest level, lowest number on ties
	function automatic logic [9:0] pick_source(input logic [47:0] elig,
		input logic [47:0][2:0] pr);
		logic [9:0] best;
		best = '0;
		for (int i = 47; i >= 0; i--) begin
			if (elig[i] && ({1'b0, pr[i]} >= best[9:6])) begin
				best = {1'b0, pr[i], 6'(i)};
			end
		end
		return best;
	endfunction : pick_source

	function automatic logic [15:0] priority_word(input logic [47:0][2:0] pr, input int r);
		logic [15:0] w;
		w = '0;
		for (int n = 0; n < 4; n++) begin
			if (4 * r + n < 48) begin
				w[4*n +: 3] = pr[4*r+n] & {3{impl_mask[4*r+n]}};
			end
		end
		return w;
	endfunction : priority_word

	logic [47:0] eligible;
	logic [9:0] winner;
	logic [3:0] win_level;
	logic [1:0] trap_idx;
	logic trap_any;
	logic [3:0] trap_level;
	logic [4:0] ridx;
	logic in_vector_space;
	logic int_allowed;

	always_comb begin
		s_d = s_q;
		s_d.pc_load = 1'b0;
		s_d.addr_err = 1'b0;
		s_d.rdata = '0;
		ridx = reg_addr - irq_ctrl_pkg::reg_source_priority_0;
		// priority zero counts as disabled
		for (int i = 0; i < 48; i++) begin
			eligible[i] = s_q.flags[i] && s_q.enables[i] && (s_q.prio[i] != 3'h0);
		end
		winner = pick_source(eligible, s_q.prio);
		win_level = winner[9:6];
		trap_any = |s_q.trap_pend;
		trap_idx = 2'h0;
		for (int t = 0; t < 4; t++) begin
			if (s_q.trap_pend[t]) begin
				trap_idx = 2'(t);
			end
		end
		trap_level = irq_ctrl_pkg::trap_level_base + {2'b00, trap_idx};
		int_allowed = (win_level > s_q.cpu_priority_level)
			&& !(s_q.nesting_disable && (s_q.depth != 4'h0))
			&& !((s_q.timed_count != '0) && (win_level <= irq_ctrl_pkg::timed_block_max));
		in_vector_space = (fetch_addr >= irq_ctrl_pkg::vector_lo)
			&& (fetch_addr <= irq_ctrl_pkg::vector_hi);

		// event set wins over a software clear in the same cycle
		if (reg_write) begin
			for (int r = 0; r < irq_ctrl_pkg::flag_regs; r++) begin
				if (reg_addr == irq_ctrl_pkg::reg_request_flags_0 + 5'(r)) begin
					s_d.flags[16*r +: 16] = reg_wdata;
				end
				if (reg_addr == irq_ctrl_pkg::reg_source_enables_0 + 5'(r)) begin
					s_d.enables[16*r +: 16] = reg_wdata;
				end
			end
			for (int r = 0; r < irq_ctrl_pkg::priority_regs; r++) begin
				if (reg_addr == irq_ctrl_pkg::reg_source_priority_0 + 5'(r)) begin
					for (int n = 0; n < 4; n++) begin
						if (4 * r + n < 48) begin
							s_d.prio[4*r+n] = reg_wdata[4*n +: 3];
						end
					end
				end
			end
			case (reg_addr)
				irq_ctrl_pkg::reg_global_control_1: begin
					s_d.nesting_disable = reg_wdata[irq_ctrl_pkg::nesting_disable_bit];
					s_d.ctrl1_low = reg_wdata[14:0];
				end
				irq_ctrl_pkg::reg_global_control_2: begin
					s_d.alt_table = reg_wdata[irq_ctrl_pkg::alt_table_bit];
					s_d.ctrl2_low = reg_wdata[13:0];
				end
				irq_ctrl_pkg::reg_processor_status: begin
					if (!s_q.nesting_disable) begin
						s_d.cpu_priority_level[2:0] = reg_wdata[irq_ctrl_pkg::ipl_low_pos +: 3];
					end
				end
				irq_ctrl_pkg::reg_timed_disable_count: begin
					s_d.timed_count = reg_wdata[irq_ctrl_pkg::timed_count_width-1:0];
				end
				default: begin
				end
			endcase
		end
		// conditions arrive already qualified by their peripheral
		s_d.flags = (s_d.flags | source_event) & impl_mask;
		s_d.enables = s_d.enables & impl_mask;

		if (instr_start && (s_q.timed_count != '0) && !(reg_write
			&& reg_addr == irq_ctrl_pkg::reg_timed_disable_count)) begin
			s_d.timed_count = s_q.timed_count - 1'b1;
		end

		// vector words are only fetched by the vector sequence
		if (fetch_valid && !fetch_is_vector && in_vector_space) begin
			s_d.addr_err = 1'b1;
		end
		s_d.trap_pend = s_d.trap_pend | trap_event | {2'b00, s_d.addr_err, 1'b0};

		case (s_q.state)
			irq_ctrl_pkg::st_idle: begin
				if (instr_start) begin
					if (trap_any && (trap_level > s_q.cpu_priority_level)) begin
						s_d.req = 1'b1;
						s_d.lvl = trap_level;
						s_d.vec = irq_ctrl_pkg::trap_vector_base + {4'h0, trap_idx};
						s_d.trap_taking = 4'h1 << trap_idx;
						s_d.state = irq_ctrl_pkg::st_present;
					end else if ((win_level != 4'h0) && int_allowed) begin
						s_d.req = 1'b1;
						s_d.lvl = win_level;
						s_d.vec = winner[5:0] + irq_ctrl_pkg::vector_offset;
						s_d.src = winner[5:0];
						s_d.trap_taking = 4'h0;
						s_d.state = irq_ctrl_pkg::st_present;
					end
				end
			end
			irq_ctrl_pkg::st_present: begin
				if (vector_ack) begin
					s_d.req = 1'b0;
					s_d.state = irq_ctrl_pkg::st_idle;
					s_d.pc_load = 1'b1;
					s_d.pc_val = vector_word;
					s_d.cpu_priority_level = s_q.lvl;
					// a fresh trap in the acknowledge cycle stays pending
					s_d.trap_pend = s_d.trap_pend & ~(s_q.trap_taking & ~trap_event
						& ~{2'b00, s_d.addr_err, 1'b0});
					if (s_q.depth < 4'(stack_depth)) begin
						s_d.stack[s_q.depth[$clog2(stack_depth+1)-1:0]] = s_q.cpu_priority_level;
						s_d.depth = s_q.depth + 4'h1;
					end
				end
			end
			default: begin
				s_d.state = irq_ctrl_pkg::st_idle;
				s_d.req = 1'b0;
			end
		endcase
		s_d.loc = irq_ctrl_pkg::vector_lo + {17'h0, s_d.vec, 1'b0}
			+ (s_d.alt_table ? irq_ctrl_pkg::alt_table_offset : 24'h0);

		if (irq_return && s_q.state == irq_ctrl_pkg::st_idle && s_q.depth != 4'h0) begin
			s_d.depth = s_q.depth - 4'h1;
			s_d.cpu_priority_level = s_q.stack[s_d.depth[$clog2(stack_depth+1)-1:0]];
		end

		if (reg_read) begin
			if (reg_addr < irq_ctrl_pkg::reg_source_enables_0) begin
				s_d.rdata = s_q.flags[16*reg_addr[1:0] +: 16];
			end else if (reg_addr < irq_ctrl_pkg::reg_source_priority_0) begin
				s_d.rdata = s_q.enables[16*(2'(reg_addr
					- irq_ctrl_pkg::reg_source_enables_0)) +: 16];
			end else if (reg_addr <= irq_ctrl_pkg::reg_source_priority_10) begin
				s_d.rdata = priority_word(s_q.prio, int'(ridx));
			end else begin
				case (reg_addr)
					irq_ctrl_pkg::reg_global_control_1: begin
						s_d.rdata = {s_q.nesting_disable, s_q.ctrl1_low};
					end
					irq_ctrl_pkg::reg_global_control_2: begin
						s_d.rdata = {s_q.alt_table, (s_q.timed_count != '0),
							s_q.ctrl2_low};
					end
					irq_ctrl_pkg::reg_core_control: begin
						s_d.rdata = 16'(s_q.cpu_priority_level[3]) << irq_ctrl_pkg::ipl3_bit;
					end
					irq_ctrl_pkg::reg_processor_status: begin
						s_d.rdata = 16'(s_q.cpu_priority_level[2:0]) << irq_ctrl_pkg::ipl_low_pos;
					end
					irq_ctrl_pkg::reg_timed_disable_count: begin
						s_d.rdata = 16'(s_q.timed_count);
					end
					default: begin
						s_d.rdata = 16'h0000;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_q <= '0;
			s_q.state <= irq_ctrl_pkg::st_idle;
			s_q.cpu_priority_level <= irq_ctrl_pkg::ipl_reset;
			s_q.flags <= {3{irq_ctrl_pkg::flags_reset}};
			s_q.enables <= {3{irq_ctrl_pkg::enables_reset}};
			s_q.prio <= {48{irq_ctrl_pkg::priority_reset}};
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_q = s_q.rdata;
	assign irq_request_q = s_q.req;
	assign irq_vector_q = s_q.vec;
	assign irq_level_q = s_q.lvl;
	assign vector_location_q = s_q.loc;
	assign pc_load_q = s_q.pc_load;
	assign pc_value_q = s_q.pc_val;
	assign address_error_q = s_q.addr_err;
	assign cpu_priority_level_q = s_q.cpu_priority_level;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_flag_set;
		@(posedge clock) disable iff (rst)
		source_event[0] |=> s_q.flags[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("event did not set its flag");

	property p_reserved_zero;
		@(posedge clock) disable iff (rst)
		(s_q.flags & ~impl_mask) == 48'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved flag set");

	sequence s_offer;
		irq_request_q && !vector_ack;
	endsequence
	property p_hold;
		@(posedge clock) disable iff (rst)
		s_offer |=> irq_request_q && $stable(irq_vector_q) && $stable(irq_level_q);
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped before ack");

	property p_above_level;
		@(posedge clock) disable iff (rst)
		$rose(irq_request_q) |-> irq_level_q > $past(cpu_priority_level_q);
	endproperty
	a_above_level: assert property (p_above_level) else $error("request not above level");

	property p_level_load;
		@(posedge clock) disable iff (rst)
		(irq_request_q && vector_ack) |=> pc_load_q && (cpu_priority_level_q == $past(irq_level_q))
			&& (pc_value_q == $past(vector_word));
	endproperty
	a_level_load: assert property (p_level_load) else $error("level not loaded on ack");

	property p_nesting;
		@(posedge clock) disable iff (rst)
		(s_q.nesting_disable && s_q.depth != 4'h0 && !trap_any) |=> !$rose(irq_request_q);
	endproperty
	a_nesting: assert property (p_nesting) else $error("nested while disabled");

	property p_ipl_locked;
		@(posedge clock) disable iff (rst)
		(reg_write && reg_addr == irq_ctrl_pkg::reg_processor_status && s_q.nesting_disable
			&& !(s_q.state == irq_ctrl_pkg::st_present && vector_ack) && !irq_return)
			|=> $stable(cpu_priority_level_q);
	endproperty
	a_ipl_locked: assert property (p_ipl_locked) else $error("level written while locked");

	property p_timed;
		@(posedge clock) disable iff (rst)
		$rose(irq_request_q) && $past(s_q.timed_count) != '0 |-> irq_level_q > 4'h6;
	endproperty
	a_timed: assert property (p_timed) else $error("low level taken in timed disable");

	property p_vector_map;
		@(posedge clock) disable iff (rst)
		$rose(irq_request_q) && irq_level_q < 4'h8 |-> irq_vector_q == s_q.src + 6'h08;
	endproperty
	a_vector_map: assert property (p_vector_map) else $error("vector number wrong");

	property p_addr_err;
		@(posedge clock) disable iff (rst)
		(fetch_valid && !fetch_is_vector && fetch_addr == 24'h0000fe) |=> address_error_q
			##0 s_q.trap_pend[1];
	endproperty
	a_addr_err: assert property (p_addr_err) else $error("vector fetch not trapped");
endmodule : irq_ctrl

// [verilog/irq_ctrl_pkg.sv]
// constants of the prioritised interrupt controller
package irq_ctrl_pkg;
	// register word indices on the software port
	localparam logic [4:0] reg_request_flags_0 = 5'h00;
	localparam logic [4:0] reg_source_enables_0 = 5'h03;
	localparam logic [4:0] reg_source_priority_0 = 5'h06;
	localparam logic [4:0] reg_source_priority_10 = 5'h10;
	localparam logic [4:0] reg_global_control_1 = 5'h11;
	localparam logic [4:0] reg_global_control_2 = 5'h12;
	localparam logic [4:0] reg_core_control = 5'h13;
	localparam logic [4:0] reg_processor_status = 5'h14;
	localparam logic [4:0] reg_timed_disable_count = 5'h15;
	localparam int flag_regs = 3;
	localparam int priority_regs = 11;
	// field positions
	localparam int nesting_disable_bit = 15;
	localparam int alt_table_bit = 15;
	localparam int timed_disable_bit = 14;
	localparam int ipl3_bit = 3;
	localparam int ipl_low_pos = 5;
	localparam int timed_count_width = 14;
	// reset values
	localparam logic [15:0] flags_reset = 16'h0000;
	localparam logic [15:0] enables_reset = 16'h0000;
	localparam logic [2:0] priority_reset = 3'h4;
	localparam logic [3:0] ipl_reset = 4'h0;
	// priority levels
	localparam logic [3:0] timed_block_max = 4'h6;
	localparam logic [3:0] trap_level_base = 4'hb;
	// vector space
	localparam logic [5:0] vector_offset = 6'h08;
	localparam logic [5:0] trap_vector_base = 6'h01;
	localparam logic [23:0] vector_lo = 24'h000004;
	localparam logic [23:0] vector_hi = 24'h0000fe;
	localparam logic [23:0] alt_table_offset = 24'h000080;
	// implemented sources per variant
	localparam logic [47:0] small_sources = 48'h0400_0b81_ffff;
	localparam logic [47:0] large_sources = 48'h0600_0bff_ffff;
	// controller sequence
	typedef enum logic [0:0] {st_idle, st_present} state_type;
endpackage : irq_ctrl_pkg

// [bench/core_model.sv]
// core side model: instruction pacing, vector fetch and return
`timescale 1ns/10ps
module core_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// controller side
	input wire logic irq_request_q,
	input wire logic [23:0] vector_location_q,
	output logic instr_start,
	output logic vector_ack,
	output logic [23:0] vector_word,
	output logic irq_return,
	// bench control
	input wire logic slow,
	input wire logic ret_cmd
);
	logic [1:0] phase_q;
	logic [2:0] wait_q;
	logic [23:0] junk_q;
	// word valid only beside the acknowledge, noise otherwise
	assign vector_word = vector_ack ? vector_location_q * 3 + 24'h100000 : junk_q;
	always_ff @(posedge clock) begin
		phase_q <= rst ? 2'h0 : phase_q + 2'h1;
		instr_start <= !rst && phase_q == 2'h3;
		junk_q <= rst ? 24'h000000 : junk_q + 24'h0a5a5b;
		wait_q <= (rst || vector_ack || !irq_request_q) ? 3'h0 : wait_q + 3'h1;
		// ack only while offered, after a short or long wait
		vector_ack <= !rst && irq_request_q && !vector_ack && wait_q >= (slow ? 3'h5 : 3'h0);
		// return only when nothing is offered
		irq_return <= !rst && ret_cmd && !irq_request_q;
	end
endmodule : core_model

// [bench/tb_top.sv]
// self-checking bench of the interrupt controller
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [47:0] source_event = 48'h0;
	logic [3:0] trap_event = 4'h0;
	logic fetch_valid = 1'b0;
	logic fetch_is_vector = 1'b0;
	logic [23:0] fetch_addr = 24'h0;
	logic slow = 1'b0;
	logic ret_cmd = 1'b0;
	logic [15:0] reg_rdata_q, d;
	logic instr_start, vector_ack, irq_return, irq_request_q, pc_load_q, address_error_q;
	logic [23:0] vector_word, vector_location_q, pc_value_q;
	logic [5:0] irq_vector_q;
	logic [3:0] irq_level_q, cpu_priority_level_q;
	int mismatches = 0;
	int total_checks = 0;
	int b;
	int alt = 0;
	logic [47:0] flag, en, m;
	logic [2:0] prio [48];
	logic [47:0] impl = irq_ctrl_pkg::large_sources;
	logic [23:0] fa [5] = '{24'h000003, 24'h0000ff, 24'h000010, 24'h000004, 24'h0000fe};
	logic [4:0] fe = 5'b11000;
	always #4 clock = ~clock;
	irq_ctrl #(.large_variant(1'b1), .stack_depth(8)) DUT (
		.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
		.source_event(source_event), .trap_event(trap_event), .instr_start(instr_start),
		.vector_ack(vector_ack), .vector_word(vector_word), .irq_return(irq_return),
		.fetch_valid(fetch_valid), .fetch_is_vector(fetch_is_vector), .fetch_addr(fetch_addr),
		.irq_request_q(irq_request_q), .irq_vector_q(irq_vector_q), .irq_level_q(irq_level_q),
		.vector_location_q(vector_location_q), .pc_load_q(pc_load_q), .pc_value_q(pc_value_q),
		.address_error_q(address_error_q), .cpu_priority_level_q(cpu_priority_level_q));
	core_model partner (
		.clock(clock), .rst(rst), .irq_request_q(irq_request_q),
		.vector_location_q(vector_location_q), .instr_start(instr_start),
		.vector_ack(vector_ack), .vector_word(vector_word), .irq_return(irq_return),
		.slow(slow), .ret_cmd(ret_cmd));
	// register image as software should see it
	function automatic logic [15:0] erd(int a);
		logic [15:0] r;
		int s;
		r = 16'h0;
		for (int n = 0; n < 16; n++) begin
			if (a < 3) r[n] = flag[16 * a + n];
			else if (a < 6) r[n] = en[16 * (a - 3) + n];
		end
		for (int n = 0; n < 4; n++) begin
			s = 4 * (a - 6) + n;
			if (a > 5 && a < 17 && s < 48) r[4 * n +: 3] = prio[s];
		end
		return r;
	endfunction : erd
	function automatic void mset(int a, logic [15:0] v);
		int s;
		for (int n = 0; n < 16; n++) begin
			if (a < 3) flag[16 * a + n] = v[n] & impl[16 * a + n];
			else if (a < 6) en[16 * (a - 3) + n] = v[n] & impl[16 * (a - 3) + n];
		end
		for (int n = 0; n < 4; n++) begin
			s = 4 * (a - 6) + n;
			if (a > 5 && a < 17 && s < 48) prio[s] = impl[s] ? v[4 * n +: 3] : 3'h0;
		end
	endfunction : mset
	function automatic int win();
		int w;
		w = -1;
		for (int s = 0; s < 48; s++)
			if (flag[s] && en[s] && prio[s] != 3'h0 && (w < 0 || prio[s] > prio[w])) w = s;
		return w;
	endfunction : win
	task wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		mset(a, v);
		#1;
	endtask : wr
	task rd(input logic [4:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = reg_rdata_q;
	endtask : rd
	task cmp(input int lo, input int hi);
		for (int a = lo; a <= hi; a++) begin
			rd(5'(a));
			`CHK(d, erd(a))
		end
	endtask : cmp
	task ev(input logic [47:0] v);
		@(posedge clock);
		source_event <= v;
		slow <= 1'($urandom);
		@(posedge clock);
		source_event <= 48'h0;
		flag = flag | (v & impl);
	endtask : ev
	task clr;
		for (int a = 0; a < 3; a++) wr(5'(a), 16'h0000);
	endtask : clr
	task ret;
		@(posedge clock);
		ret_cmd <= 1'b1;
		@(posedge clock);
		ret_cmd <= 1'b0;
		repeat (3) @(posedge clock);
	endtask : ret
	task quiet(input int n);
		repeat (n) @(posedge clock) #1 `CHK(irq_request_q, 1'b0)
	endtask : quiet
	task serve(input int v, input int l);
		int k;
		logic [23:0] loc;
		k = 0;
		loc = 24'(4 + 2 * v + alt);
		while (irq_request_q !== 1'b1 && k < 60) @(posedge clock) #1 k++;
		`CHK(irq_vector_q, 6'(v))
		`CHK(irq_level_q, 4'(l))
		`CHK(vector_location_q, loc)
		while (vector_ack !== 1'b1 && k < 80) @(posedge clock) #1 k++;
		`CHK(irq_vector_q, 6'(v))
		@(posedge clock) #1 `CHK(pc_load_q, 1'b1)
		`CHK(pc_value_q, loc * 3 + 24'h100000)
		`CHK(cpu_priority_level_q, 4'(l))
		`CHK(irq_request_q, 1'b0)
	endtask : serve
	task results;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results
	initial begin
		#400000;
		mismatches++;
		results();
	end
	initial begin
		void'($urandom(85));
		flag = 48'h0;
		en = 48'h0;
		for (int s = 0; s < 48; s++) prio[s] = impl[s] ? 3'h4 : 3'h0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		cmp(0, 16);
		rd(5'h1f);
		`CHK(d, 16'h0000)
		$display("test reset_values done");
		for (int a = 0; a < 17; a++) begin
			wr(5'(a), 16'($urandom));
			cmp(a, a);
			if (a < 6) wr(5'(a), 16'h0000);
		end
		wr(5'h1f, 16'hffff);
		rd(5'h1f);
		`CHK(d, 16'h0000)
		$display("test register_access done");
		ev(48'h1 << 26);
		for (int i = 0; i < 4; i++) ev(48'h1 << ($urandom % 48));
		quiet(4);
		cmp(0, 2);
		clr();
		cmp(0, 2);
		$display("test request_flags done");
		for (int a = 3; a < 6; a++) wr(5'(a), 16'hffff);
		wr(5'h06, 16'h0555);
		for (int it = 0; it < 8; it++) begin
			m = (48'h1 << ($urandom % 48)) | (48'h1 << ($urandom % 48));
			ev(it == 0 ? 48'he : m | (48'h1 << ($urandom % 48)));
			b = win();
			if (b >= 0) serve(b + 8, prio[b]);
			else quiet(12);
			clr();
			if (b >= 0) ret();
			`CHK(cpu_priority_level_q, 4'h0)
		end
		$display("test arbitration done");
		wr(5'h06, 16'h0065);
		wr(5'h14, 16'h00a0);
		`CHK(cpu_priority_level_q, 4'h5)
		ev(48'h1);
		quiet(12);
		ev(48'h2);
		serve(9, 6);
		wr(5'h11, 16'h8000);
		wr(5'h06, 16'h0765);
		ev(48'h4);
		quiet(12);
		wr(5'h14, 16'h0000);
		`CHK(cpu_priority_level_q, 4'h6)
		wr(5'h11, 16'h0000);
		serve(10, 7);
		clr();
		ret();
		ret();
		`CHK(cpu_priority_level_q, 4'h5)
		wr(5'h14, 16'h0000);
		$display("test nesting done");
		wr(5'h15, 16'h0006);
		rd(5'h12);
		`CHK(d[14], 1'b1)
		ev(48'h2);
		quiet(8);
		serve(9, 6);
		rd(5'h12);
		`CHK(d[14], 1'b0)
		clr();
		ret();
		$display("test timed_disable done");
		for (int i = 0; i < 5; i++) begin
			@(posedge clock);
			fetch_valid <= 1'b1;
			fetch_is_vector <= (i == 2);
			fetch_addr <= fa[i];
			@(posedge clock);
			fetch_valid <= 1'b0;
			#1 `CHK(address_error_q, fe[i])
			if (fe[i]) begin
				serve(2, 12);
				rd(5'h13);
				`CHK(d[3], 1'b1)
				ret();
			end
		end
		$display("test fetch_guard done");
		wr(5'h12, 16'h8000);
		rd(5'h12);
		`CHK(d, 16'h8000)
		alt = 'h80;
		@(posedge clock);
		slow <= 1'b1;
		trap_event <= 4'h1;
		source_event <= 48'h4;
		@(posedge clock);
		trap_event <= 4'h0;
		source_event <= 48'h0;
		flag = flag | 48'h4;
		serve(1, 11);
		ret();
		serve(10, 7);
		clr();
		ret();
		`CHK(cpu_priority_level_q, 4'h0)
		$display("test trap_order done");
		results();
	end
endmodule : tb_top
